// ==== inc/hcg_pkg.sv ====
// ****************************************************************
// host i/o glue constants
// ****************************************************************
package hcg_pkg;

	// ****************************************************************
	// i/o offsets on the host i/o bus
	// ****************************************************************
	localparam logic [15:0] HCG_OFS_CTRL0  = 16'h0000; // system_reset_mute_control, write
	localparam logic [15:0] HCG_OFS_CTRL1  = 16'h0001; // interrupt_led_calibrate_control, write
	localparam logic [15:0] HCG_OFS_DIGITAL_IO_CONTROL_REG  = 16'h0004; // digital_io_control_reg, write
	localparam logic [15:0] HCG_OFS_HDRM   = 16'h0008; // level_meter_matrix, write
	localparam logic [15:0] HCG_OFS_DISP   = 16'h000E; // display_data_latch, write
	localparam logic [15:0] HCG_OFS_PEDAL  = 16'h0090; // pedal converter start / result
	localparam logic [15:0] HCG_OFS_STAT0  = 16'h0000; // status 0, read
	localparam logic [15:0] HCG_OFS_STAT1  = 16'h0002; // status 1, read
	localparam logic [15:0] HCG_OFS_STAT2  = 16'h0006; // status 2, read

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int HCG_CTRL0_MUTE_N   = 5;
	localparam int HCG_CTRL1_LED_EN   = 5;
	localparam int HCG_CTRL1_CAL_N    = 4;
	localparam int HCG_DIGITAL_IO_CONTROL_REG_SRC_HI   = 7;
	localparam int HCG_DIGITAL_IO_CONTROL_REG_SRC_LO   = 6;
	localparam int HCG_HDRM_OUTLVL    = 7;
	localparam int HCG_HDRM_RCOL_N    = 6;
	localparam int HCG_HDRM_LCOL_N    = 5;
	localparam int HCG_HDRM_OVLD_N    = 4;
	localparam int HCG_HDRM_ROWS_HI   = 3;
	localparam int HCG_STAT0_TIP      = 7;
	localparam int HCG_STAT0_RING     = 0;
	localparam int HCG_STAT1_BUSY     = 7;
	localparam int HCG_STAT2_DONE_N   = 7;

	// ****************************************************************
	// reset values and clock source codes
	// ****************************************************************
	localparam logic [7:0] HCG_REG_RST = 8'h00;
	localparam logic [7:0] HCG_RD_ZERO = 8'h00;

	typedef enum logic [1:0] {
		HCG_SRC_INT44 = 2'h0,
		HCG_SRC_INT48 = 2'h1,
		HCG_SRC_EXT   = 2'h2,
		HCG_SRC_OFF   = 2'h3
	} hcg_src_type;

endpackage : hcg_pkg

// ==== rtl/hcg_clock_div.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// wordclock source select and divide
// ****************************************************************
module hcg_clock_div
	import hcg_pkg::*;
(
	input  wire logic       sys_clk_i,
	input  wire logic       resetn_i,
	input  wire logic       ce_i,
	input  wire logic [1:0] src_sel_i,
	input  wire logic       ref_44k_i,
	input  wire logic       ref_48k_i,
	input  wire logic       ref_ext_i,
	output logic            master_clk_o,
	output logic            half_clk_o
);

	logic mux_out;
	logic master_ff;
	logic half_ff;
	logic master_rise;

	// source mux; the off code ties the clock low
	assign mux_out = (src_sel_i == HCG_SRC_INT44) ? ref_44k_i :
	                 (src_sel_i == HCG_SRC_INT48) ? ref_48k_i :
	                 (src_sel_i == HCG_SRC_EXT)   ? ref_ext_i : 1'b0; // R15 R19
	assign master_rise = mux_out & ~master_ff;

	// master follows the mux, half toggles on each master rise for 50 percent duty
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			master_ff <= 1'b0;
			half_ff   <= 1'b0;
		end else if (ce_i) begin
			master_ff <= mux_out; // R16 R17
			half_ff   <= master_rise ? ~half_ff : half_ff; // R18
		end
	end

	assign master_clk_o = master_ff;
	assign half_clk_o   = half_ff;

endmodule : hcg_clock_div
`default_nettype wire

// ==== rtl/hcg_io_glue.sv ====
// How it works
// R01 - host scans the two meter columns in turn, 2ms each of 4ms.
// R02 - two active-low column selects and five active-low row lines drive the meter.
// R03 - led outputs float while led enable is low, also through reset.
// R04 - meter register: level select b7, right b6, left b5, overload b4, rows b3..0.
// R05 - level select high picks +4 dBu, low picks -10 dBu.
// R06 - display latch passes host data while strobe is low, holds afterwards.
// R07 - display busy flag reads at status 1 bit 7; host waits for low.
// R08 - write to pedal location starts conversion, read there returns 8-bit result.
// R09 - conversion done goes low when result valid; host waits before reading.
// R10 - footswitch tip and ring levels read at status 0 bits 7 and 0.
// R11 - music thru copies the input, or repeats the output in test mode.
// R12 - host holds calibrate low at power-up and on every rate change.
// R13 - mute low opens relay and forces three serial audio streams to zero.
// R14 - mute high closes relay and passes gated streams unchanged.
// R15 - two-bit source field picks 44.1k, 48k, external, or off low.
// R16 - mux output is the master clock, divided down for other clocks.
// R17 - master clock runs at 256 times wordclock, 50 percent duty.
// R18 - half-rate clock at 128 times wordclock derived from master.
// R19 - internal sources come from 11.2896 and 12.2880 MHz references.
// R20 - every control register output starts low after reset.
// R21 - write-only offsets return nothing; reads there select the read function.
// R22 - write registers capture host data at strobe end, hold until next write.
`timescale 1ns/1ps
`default_nettype none
module hcg_io_glue
	import hcg_pkg::*;
#(
	parameter int ADDR_W = 16
) (
	input  wire logic              sys_clk_i,
	input  wire logic              resetn_i,
	input  wire logic              ce_i,
	input  wire logic [ADDR_W-1:0] host_addr_i,
	input  wire logic [7:0]        host_data_bus_i,
	input  wire logic              host_wr_n_i,
	input  wire logic              host_rd_n_i,
	output logic       [7:0]       host_rd_data_o,
	output logic                   host_rd_oe_o,
	input  wire logic              display_busy_flag_i,
	input  wire logic              pedal_conversion_done_n_i,
	input  wire logic [7:0]        pedal_result_i,
	input  wire logic              pedal_switch_tip_i,
	input  wire logic              pedal_switch_ring_i,
	input  wire logic              music_link_in_buffered_i,
	input  wire logic              music_link_out_raw_i,
	input  wire logic              music_thru_test_sel_i,
	input  wire logic [2:0]        audio_serial_i,
	input  wire logic              ref_44k_i,
	input  wire logic              ref_48k_i,
	input  wire logic              ref_ext_i,
	output logic                   left_meter_column_n_o,
	output logic                   right_meter_column_n_o,
	output logic                   overload_row_n_o,
	output logic       [3:0]       level_row_n_o,
	output logic                   led_output_enable_o,
	output logic                   high_output_level_sel_o,
	output logic       [7:0]       display_data_o,
	output logic                   display_write_strobe_n_o,
	output logic                   pedal_converter_select_n_o,
	output logic                   pedal_start_n_o,
	output logic                   pedal_read_n_o,
	output logic                   music_thru_o,
	output logic                   converter_calibrate_n_o,
	output logic                   mute_n_o,
	output logic       [2:0]       audio_gated_o,
	output logic                   master_sample_clock_o,
	output logic                   half_master_sample_clock_o
);

	initial begin
		if (ADDR_W < 8 || ADDR_W > 16) $error("ADDR_W must be 8 to 16");
	end

	// ****************************************************************
	// input synchronisers
	// ****************************************************************
	localparam int SYNC_W = ADDR_W + 31;

	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] sync1_ff;
	logic [SYNC_W-1:0] sync2_ff;

	assign pins_raw = {host_addr_i, host_data_bus_i, host_wr_n_i, host_rd_n_i,
	                   display_busy_flag_i, pedal_conversion_done_n_i, pedal_result_i,
	                   pedal_switch_tip_i, pedal_switch_ring_i, music_link_in_buffered_i,
	                   music_link_out_raw_i, music_thru_test_sel_i, audio_serial_i,
	                   ref_44k_i, ref_48k_i, ref_ext_i};

	// every pin but reset and the clock enable is foreign to sys_clk, so those pass two stages
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync1_ff <= '1;
			sync2_ff <= '1;
		end else if (ce_i) begin
			sync1_ff <= pins_raw;
			sync2_ff <= sync1_ff;
		end
	end

	logic [ADDR_W-1:0] addr_s;
	logic [7:0]        data_s;
	logic              wr_n_s;
	logic              rd_n_s;
	logic              busy_s;
	logic              done_n_s;
	logic [7:0]        result_s;
	logic              tip_s;
	logic              ring_s;
	logic              midi_in_s;
	logic              midi_out_s;
	logic              test_sel_s;
	logic [2:0]        aud_s;
	logic              r44_s;
	logic              r48_s;
	logic              rext_s;

	assign {addr_s, data_s, wr_n_s, rd_n_s, busy_s, done_n_s, result_s, tip_s, ring_s,
	        midi_in_s, midi_out_s, test_sel_s, aud_s, r44_s, r48_s, rext_s} = sync2_ff;

	// ****************************************************************
	// address decode
	// ****************************************************************
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] ofs);
		hit = ({{(16-ADDR_W){1'b0}}, a} == ofs);
	endfunction : hit

	logic [ADDR_W-1:0] addr_hold_ff;
	logic [7:0]        data_hold_ff;
	logic              wr_n_prev_ff;
	logic              wr_rise;
	logic              wr_act;
	logic              rd_act;

	// the strobe edge is seen a cycle late, so decode from values held while it was low
	assign wr_act  = ~wr_n_s;
	assign rd_act  = ~rd_n_s;
	assign wr_rise = wr_n_s & ~wr_n_prev_ff; // R22

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			addr_hold_ff <= '0;
			data_hold_ff <= HCG_REG_RST;
			wr_n_prev_ff <= 1'b1;
		end else if (ce_i) begin
			wr_n_prev_ff <= wr_n_s;
			if (wr_act) begin
				addr_hold_ff <= addr_s;
				data_hold_ff <= data_s;
			end
		end
	end

	logic we_ctrl0;
	logic we_ctrl1;
	logic we_digital_io_control_reg;
	logic we_hdrm;

	assign we_ctrl0 = wr_rise & hit(addr_hold_ff, HCG_OFS_CTRL0);
	assign we_ctrl1 = wr_rise & hit(addr_hold_ff, HCG_OFS_CTRL1);
	assign we_digital_io_control_reg = wr_rise & hit(addr_hold_ff, HCG_OFS_DIGITAL_IO_CONTROL_REG);
	assign we_hdrm  = wr_rise & hit(addr_hold_ff, HCG_OFS_HDRM);

	// ****************************************************************
	// write-only registers
	// ****************************************************************
	logic [7:0] ctrl0_ff;
	logic [7:0] ctrl1_ff;
	logic [7:0] digital_io_control_reg_ff;
	logic [7:0] hdrm_ff;

	// all control outputs come up low: muted, calibrating, leds dark
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl0_ff <= HCG_REG_RST; // R20
			ctrl1_ff <= HCG_REG_RST;
			digital_io_control_reg_ff <= HCG_REG_RST;
			hdrm_ff  <= HCG_REG_RST;
		end else if (ce_i) begin
			if (we_ctrl0) ctrl0_ff <= data_hold_ff; // R22
			if (we_ctrl1) ctrl1_ff <= data_hold_ff;
			if (we_digital_io_control_reg) digital_io_control_reg_ff <= data_hold_ff;
			if (we_hdrm)  hdrm_ff  <= data_hold_ff; // R04
		end
	end

	// meter lines float unless enabled; the oe covers all seven lines
	assign led_output_enable_o     = ctrl1_ff[HCG_CTRL1_LED_EN]; // R03
	assign right_meter_column_n_o  = hdrm_ff[HCG_HDRM_RCOL_N]; // R02
	assign left_meter_column_n_o   = hdrm_ff[HCG_HDRM_LCOL_N];
	assign overload_row_n_o        = hdrm_ff[HCG_HDRM_OVLD_N];
	assign level_row_n_o           = hdrm_ff[HCG_HDRM_ROWS_HI:0];
	assign high_output_level_sel_o = hdrm_ff[HCG_HDRM_OUTLVL]; // R05
	assign converter_calibrate_n_o = ctrl1_ff[HCG_CTRL1_CAL_N];
	assign mute_n_o                = ctrl0_ff[HCG_CTRL0_MUTE_N]; // R14

	// ****************************************************************
	// display latch, pedal converter strobes
	// ****************************************************************
	logic       disp_act;
	logic       pedal_act;
	logic [7:0] disp_ff;
	logic       disp_stb_n_ff;
	logic       ped_sel_n_ff;
	logic       ped_wr_n_ff;
	logic       ped_rd_n_ff;

	assign disp_act  = wr_act & hit(addr_s, HCG_OFS_DISP);
	assign pedal_act = (wr_act | rd_act) & hit(addr_s, HCG_OFS_PEDAL);

	// transparent while strobed, frozen after, so the display sees held data
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			disp_ff       <= HCG_REG_RST;
			disp_stb_n_ff <= 1'b1;
			ped_sel_n_ff  <= 1'b1;
			ped_wr_n_ff   <= 1'b1;
			ped_rd_n_ff   <= 1'b1;
		end else if (ce_i) begin
			if (disp_act) disp_ff <= data_s; // R06
			disp_stb_n_ff <= ~disp_act;
			ped_sel_n_ff  <= ~pedal_act; // R08
			ped_wr_n_ff   <= ~(pedal_act & wr_act);
			ped_rd_n_ff   <= ~(pedal_act & rd_act);
		end
	end

	assign display_data_o             = disp_ff;
	assign display_write_strobe_n_o   = disp_stb_n_ff;
	assign pedal_converter_select_n_o = ped_sel_n_ff;
	assign pedal_start_n_o            = ped_wr_n_ff;
	assign pedal_read_n_o             = ped_rd_n_ff;

	// ****************************************************************
	// read path
	// ****************************************************************
	logic [7:0] stat0;
	logic [7:0] stat1;
	logic [7:0] stat2;
	logic [7:0] rd_mux;
	logic       rd_map;
	logic [7:0] rd_data_ff;
	logic       rd_oe_ff;

	assign stat0 = {tip_s, 6'h00, ring_s}; // R10
	assign stat1 = {busy_s, 7'h00}; // R07
	assign stat2 = {done_n_s, 7'h00}; // R09

	// write-only offsets have no readback; only status and pedal result answer
	assign rd_map = hit(addr_s, HCG_OFS_STAT0) | hit(addr_s, HCG_OFS_STAT1) |
	                hit(addr_s, HCG_OFS_STAT2) | hit(addr_s, HCG_OFS_PEDAL); // R21
	assign rd_mux = hit(addr_s, HCG_OFS_STAT0) ? stat0 :
	                hit(addr_s, HCG_OFS_STAT1) ? stat1 :
	                hit(addr_s, HCG_OFS_STAT2) ? stat2 :
	                hit(addr_s, HCG_OFS_PEDAL) ? result_s : HCG_RD_ZERO; // R08

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rd_data_ff <= HCG_RD_ZERO;
			rd_oe_ff   <= 1'b0;
		end else if (ce_i) begin
			rd_data_ff <= (rd_act & rd_map) ? rd_mux : HCG_RD_ZERO;
			rd_oe_ff   <= rd_act & rd_map;
		end
	end

	assign host_rd_data_o = rd_data_ff;
	assign host_rd_oe_o   = rd_oe_ff;

	// ****************************************************************
	// music thru and mute gating
	// ****************************************************************
	logic       thru_ff;
	logic [2:0] gated_ff;

	// audio is gated in this domain, trading a few ns of skew for clean edges
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			thru_ff  <= 1'b1;
			gated_ff <= 3'h0;
		end else if (ce_i) begin
			thru_ff  <= test_sel_s ? midi_out_s : midi_in_s; // R11
			gated_ff <= aud_s & {3{ctrl0_ff[HCG_CTRL0_MUTE_N]}}; // R13 R14
		end
	end

	assign music_thru_o  = thru_ff;
	assign audio_gated_o = gated_ff;

	// ****************************************************************
	// sample clocks
	// ****************************************************************
	logic [1:0] src_sel;

	assign src_sel = {digital_io_control_reg_ff[HCG_DIGITAL_IO_CONTROL_REG_SRC_HI], digital_io_control_reg_ff[HCG_DIGITAL_IO_CONTROL_REG_SRC_LO]}; // R15

	hcg_clock_div u_clk (
		.sys_clk_i    (sys_clk_i),
		.resetn_i     (resetn_i),
		.ce_i         (ce_i),
		.src_sel_i    (src_sel),
		.ref_44k_i    (r44_s),
		.ref_48k_i    (r48_s),
		.ref_ext_i    (rext_s),
		.master_clk_o (master_sample_clock_o),
		.half_clk_o   (half_master_sample_clock_o)
	);

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	a_hdrm_capture: assert property (ce_i && we_hdrm |=> level_row_n_o == $past(data_hold_ff[HCG_HDRM_ROWS_HI:0]) // R04
		&& overload_row_n_o == $past(data_hold_ff[HCG_HDRM_OVLD_N]))
		else $error("meter register did not capture");
	a_led_dark: assert property (ce_i && we_ctrl1 && !data_hold_ff[HCG_CTRL1_LED_EN] // R03
		|=> !led_output_enable_o)
		else $error("led enable not cleared");
	a_level_sel: assert property (ce_i && we_hdrm |=> high_output_level_sel_o == $past(data_hold_ff[HCG_HDRM_OUTLVL])) // R05
		else $error("level select wrong");
	a_disp_pass: assert property (ce_i && disp_act |=> display_data_o == $past(data_s)) // R06
		else $error("display latch not transparent");
	a_disp_hold: assert property (ce_i && !disp_act |=> $stable(display_data_o)) // R06
		else $error("display latch not holding");
	a_pedal_sel: assert property (ce_i && pedal_act |=> !pedal_converter_select_n_o) // R08
		else $error("pedal select missing");
	a_mute_zero: assert property (ce_i && !mute_n_o |=> audio_gated_o == 3'h0) // R13
		else $error("muted audio not zero");
	a_mute_pass: assert property (ce_i && mute_n_o |=> audio_gated_o == $past(aud_s)) // R14
		else $error("unmuted audio altered");
	a_thru_sel: assert property (ce_i && !test_sel_s |=> music_thru_o == $past(midi_in_s)) // R11
		else $error("thru not copying input");
	a_clk_off: assert property (ce_i && src_sel == HCG_SRC_OFF ##1 ce_i && src_sel == HCG_SRC_OFF // R15
		|-> !master_sample_clock_o)
		else $error("master clock not held low");

	c_hdrm_write: cover property (we_hdrm);
	c_disp_write: cover property (disp_act ##[1:10] !disp_act);
	c_pedal_read: cover property (rd_oe_ff && hit(addr_s, HCG_OFS_PEDAL));
	c_unmute: cover property ($rose(mute_n_o));

endmodule : hcg_io_glue
`default_nettype wire

// ==== bench/hcg_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// host processor on the i/o bus
// ****************************************************************
module hcg_host_model
	import hcg_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic [7:0]  rd_data_i,
	input  wire logic        rd_oe_i,
	output logic      [15:0] addr_o,
	output logic      [7:0]  data_o,
	output logic             wr_n_o,
	output logic             rd_n_o
);
	// idle bus: strobes high, released lines flip so stale values never look valid
	initial begin
		addr_o = 16'hFFFF;
		data_o = 8'h00;
		wr_n_o = 1'b1;
		rd_n_o = 1'b1;
	end

	// every drive change lands 1 ns after a rising edge
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : idle

	// strobe held four cycles so the two-flop sync sees it well inside the window
	task automatic wr_start(input logic [15:0] a, input logic [7:0] d);
		addr_o = a;
		data_o = d;
		wr_n_o = 1'b0;
		idle(4);
	endtask : wr_start

	// address and data kept past the synced release, then released
	task automatic wr_end();
		wr_n_o = 1'b1;
		idle(3);
		addr_o = ~addr_o;
		data_o = ~data_o;
		idle(1);
	endtask : wr_end

	task automatic io_write(input logic [15:0] a, input logic [7:0] d);
		wr_start(a, d);
		wr_end();
	endtask : io_write

	// answer appears three edges after the strobe falls and is taken on the fourth
	task automatic io_read(input logic [15:0] a, output logic [7:0] d, output logic oe);
		addr_o = a;
		rd_n_o = 1'b0;
		idle(4);
		d = rd_data_i;
		oe = rd_oe_i;
		rd_n_o = 1'b1;
		idle(3);
		addr_o = ~addr_o;
		idle(1);
	endtask : io_read

	// poll a status bit until it reads low, with a bounded number of reads
	task automatic wait_low(input logic [15:0] a, input int b, output logic ok);
		logic [7:0] d;
		logic       oe;
		ok = 1'b0;
		for (int n = 0; n < 20 && !ok; n++) begin
			io_read(a, d, oe);
			ok = (d[b] === 1'b0);
		end
	endtask : wait_low

	// calibrate held low around every sample-rate change
	task automatic set_rate(input logic [1:0] src, input logic led);
		io_write(HCG_OFS_CTRL1, {2'b00, led, 5'h00});
		io_write(HCG_OFS_DIGITAL_IO_CONTROL_REG, {src, 6'h00});
		io_write(HCG_OFS_CTRL1, {2'b00, led, 1'b1, 4'h0});
	endtask : set_rate
endmodule : hcg_host_model
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// self-checking bench for the host i/o glue
// ****************************************************************
module testbench
	import hcg_pkg::*;
;
	logic        sys_clk_i = 1'b0;
	logic        resetn_i  = 1'b0;
	logic [15:0] addr;
	logic [7:0]  wdata, rd_data, ddata, result = 8'h00;
	logic        wr_n, rd_n, rd_oe, lcol_n, rcol_n, ovl_n, led_oe, hilvl, dstb_n;
	logic        psel_n, pst_n, prd_n, thru, cal_n, mute_n, mclk, hclk;
	logic        busy = 1'b0, done_n = 1'b1, tip = 1'b1, ring = 1'b1;
	logic        mi = 1'b0, mo = 1'b0, msel = 1'b0, ce = 1'b1;
	logic [2:0]  aud = 3'h0, refs = 3'h0, agated;
	logic [3:0]  rows_n;
	logic [31:0] seed = 32'h69D47691;
	logic [15:0] wo_ofs [5] = '{HCG_OFS_CTRL1, HCG_OFS_DIGITAL_IO_CONTROL_REG, HCG_OFS_HDRM, HCG_OFS_DISP, 16'h0050};
	int          miscompares = 0, num_checks = 0, cycles = 0;

	always #12.5 sys_clk_i = ~sys_clk_i;

	// three unrelated reference patterns; the sync flops see them at 40 MHz
	always @(posedge sys_clk_i) begin
		#1;
		refs[0] = (cycles % 2 == 0) ? ~refs[0] : refs[0];
		refs[1] = (cycles % 3 == 0) ? ~refs[1] : refs[1];
		refs[2] = (cycles % 5 == 0) ? ~refs[2] : refs[2];
	end

	// hang guard: the whole sequence needs under a thousand cycles
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares = miscompares + 1;
			$display("[ERR] %0t timeout", $time);
			end_of_test();
		end
	end

	hcg_io_glue dut (
		.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ce_i(ce), .host_addr_i(addr),
		.host_data_bus_i(wdata), .host_wr_n_i(wr_n), .host_rd_n_i(rd_n),
		.host_rd_data_o(rd_data), .host_rd_oe_o(rd_oe), .display_busy_flag_i(busy),
		.pedal_conversion_done_n_i(done_n), .pedal_result_i(result),
		.pedal_switch_tip_i(tip), .pedal_switch_ring_i(ring),
		.music_link_in_buffered_i(mi), .music_link_out_raw_i(mo), .music_thru_test_sel_i(msel),
		.audio_serial_i(aud), .ref_44k_i(refs[0]), .ref_48k_i(refs[1]), .ref_ext_i(refs[2]),
		.left_meter_column_n_o(lcol_n), .right_meter_column_n_o(rcol_n),
		.overload_row_n_o(ovl_n), .level_row_n_o(rows_n), .led_output_enable_o(led_oe),
		.high_output_level_sel_o(hilvl), .display_data_o(ddata),
		.display_write_strobe_n_o(dstb_n), .pedal_converter_select_n_o(psel_n),
		.pedal_start_n_o(pst_n), .pedal_read_n_o(prd_n), .music_thru_o(thru),
		.converter_calibrate_n_o(cal_n), .mute_n_o(mute_n), .audio_gated_o(agated),
		.master_sample_clock_o(mclk), .half_master_sample_clock_o(hclk)
	);

	hcg_host_model host (
		.clk_i(sys_clk_i), .rd_data_i(rd_data), .rd_oe_i(rd_oe),
		.addr_o(addr), .data_o(wdata), .wr_n_o(wr_n), .rd_n_o(rd_n)
	);

	function automatic logic [7:0] rnd_byte();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction : rnd_byte

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// master must track the selected reference at some fixed small latency
	task automatic clk_check(input logic [1:0] s);
		logic [47:0] m, r, t;
		logic        ph;
		int          ok, rises, tog;
		ok = 0;
		rises = 0;
		tog = 0;
		ph = hclk;
		for (int i = 0; i < 48; i++) begin
			@(posedge sys_clk_i);
			#2;
			m[i] = mclk;
			r[i] = (s == HCG_SRC_OFF) ? 1'b0 : refs[s];
			rises += (i > 0 && m[i] && !m[i-1]) ? 1 : 0;
			tog += (hclk !== ph) ? 1 : 0;
			ph = hclk;
		end
		for (int d = 2; d < 5; d++) begin
			t = r << d;
			ok = (m[47:8] === t[47:8]) ? 1 : ok;
		end
		chk(8'(ok), 8'h01);
		chk(8'(tog >= rises - 1 && tog <= rises + 1), 8'h01);
		host.idle(1);
	endtask : clk_check

	task automatic end_of_test();
		if (miscompares == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		logic [7:0] v, d;
		logic       oe, ok;
		repeat (2) @(posedge sys_clk_i);
		#1;
		resetn_i = 1'b1;
		chk({led_oe, mute_n, cal_n, hilvl, dstb_n, psel_n, 2'b00}, 8'h0C);
		chk({5'h00, agated}, 8'h00);
		host.idle(2);
		for (int k = 0; k < 4; k++) begin
			host.set_rate(2'(k), 1'b1);
			chk({6'h00, led_oe, cal_n}, 8'h03);
			clk_check(2'(k));
		end
		// corners first, then the host scans the two columns in turn
		for (int i = 0; i < 10; i++) begin
			v = (i < 2) ? {8{i[0]}} : rnd_byte();
			v[6:5] = (i < 2) ? v[6:5] : (i[0] ? 2'b01 : 2'b10);
			host.io_write(HCG_OFS_HDRM, v);
			chk({hilvl, rcol_n, lcol_n, ovl_n, rows_n}, v);
			host.io_write(16'h0050, ~v);
			host.idle(5);
			chk({hilvl, rcol_n, lcol_n, ovl_n, rows_n}, v);
		end
		// a write while the clock enable is low must leave the meter register frozen
		ce = 1'b0;
		host.io_write(HCG_OFS_HDRM, ~v);
		ce = 1'b1;
		host.idle(4);
		chk({hilvl, rcol_n, lcol_n, ovl_n, rows_n}, v);
		for (int i = 0; i < 6; i++) begin
			v = rnd_byte();
			aud = v[2:0];
			host.io_write(HCG_OFS_CTRL0, {2'b00, v[3], 5'h00});
			chk({5'h00, agated}, v[3] ? {5'h00, aud} : 8'h00);
			chk({7'h00, mute_n}, {7'h00, v[3]});
		end
		for (int i = 0; i < 8; i++) begin
			{msel, mi, mo} = i[2:0];
			host.idle(5);
			chk({7'h00, thru}, {7'h00, msel ? mo : mi});
		end
		for (int i = 0; i < 4; i++) begin
			v = rnd_byte();
			{busy, done_n, tip, ring} = (i < 2) ? {4{i[0]}} : v[3:0];
			host.idle(3);
			host.io_read(HCG_OFS_STAT0, d, oe);
			chk(d & 8'h81, {tip, 6'h00, ring});
			host.io_read(HCG_OFS_STAT1, d, oe);
			chk({d[7], 6'h00, oe}, {busy, 6'h00, 1'b1});
			host.io_read(HCG_OFS_STAT2, d, oe);
			chk({d[7], 7'h00}, {done_n, 7'h00});
		end
		foreach (wo_ofs[j]) begin
			host.io_read(wo_ofs[j], d, oe);
			chk(d | {7'h00, oe}, 8'h00);
		end
		// two characters back to back; the latch must hold once the bus moves on
		busy = 1'b0;
		for (int i = 0; i < 2; i++) begin
			v = rnd_byte();
			host.wait_low(HCG_OFS_STAT1, HCG_STAT1_BUSY, ok);
			host.wr_start(HCG_OFS_DISP, v);
			chk({dstb_n, 7'h00} | (ddata ^ v), 8'h00);
			host.wr_end();
			chk({dstb_n, 7'h00} | (ddata ^ v), 8'h80);
		end
		result = rnd_byte();
		done_n = 1'b1;
		host.wr_start(HCG_OFS_PEDAL, 8'h00);
		chk({5'h00, psel_n, pst_n, prd_n}, 8'h01);
		host.wr_end();
		chk({5'h00, psel_n, pst_n, prd_n}, 8'h07);
		fork
			begin
				host.idle(30);
				done_n = 1'b0;
			end
			host.wait_low(HCG_OFS_STAT2, HCG_STAT2_DONE_N, ok);
		join
		chk({7'h00, ok}, 8'h01);
		host.io_read(HCG_OFS_PEDAL, d, oe);
		chk(d, result);
		chk({7'h00, oe}, 8'h01);
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
